/* File: hw/otov_map.svh */
// register map, field positions, reset values and timing counts of the output test block
`ifndef OTOV_MAP_SVH
`define OTOV_MAP_SVH

// ----------------------------------------
// register word offsets
// ----------------------------------------
`define OTOV_ADDR_RELAY_FORCE 8'h00
`define OTOV_ADDR_STATUS 8'h01
`define OTOV_ADDR_RELAY_DUR 8'h04
`define OTOV_ADDR_ANA_FORCE 8'h08
`define OTOV_ADDR_ANA_CFG 8'h0C
`define OTOV_ADDR_ANA_MIN 8'h10
`define OTOV_ADDR_ANA_MAX 8'h14

// ----------------------------------------
// field positions
// ----------------------------------------
`define OTOV_ST_COIL_LSB 0
`define OTOV_ST_HELD_LSB 4
`define OTOV_ST_TEST_BIT 8

// ----------------------------------------
// reset values
// ----------------------------------------
`define OTOV_RST_ANA_CFG 5'h00
`define OTOV_RST_ANA_MIN 16'h0000
`define OTOV_RST_ANA_MAX 16'h0064

// ----------------------------------------
// limits and timing
// ----------------------------------------
`define OTOV_CLK_HZ 50000000
`define OTOV_TICK_S 1
`define OTOV_DUR_MAX 16'h012C
`define OTOV_PCT_MAX 7'h64
`define OTOV_UA_1MA 16'h03E8
`define OTOV_UA_4MA 16'h0FA0
`define OTOV_UA_20MA 16'h4E20
`define OTOV_PF_MIN (-99)
`define OTOV_PF_MAX 100
`define OTOV_PF_SPAN 199

`endif

/* File: hw/otov_pkg.sv */
// types shared by the output test and override block
`default_nettype none
package otov_pkg;

	typedef enum logic [1:0] {OTOV_FRC_OFF, OTOV_FRC_ON, OTOV_FRC_DROP} otov_force_t;

	typedef enum logic [1:0] {OTOV_LOOP_0_1, OTOV_LOOP_0_20, OTOV_LOOP_4_20} otov_loop_t;

	typedef struct packed {
		logic pf_step;
		logic pf_sel;
		otov_loop_t loop;
		logic enable;
	} otov_ana_cfg_t;

endpackage
`default_nettype wire

/* File: hw/otov_relay_force.sv */
// force and timeout of one contact output
`default_nettype none
module otov_relay_force #(
	parameter int DUR_W = 9
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// settings and timebase
	input wire otov_pkg::otov_force_t force_mode,
	input wire logic [DUR_W-1:0] duration,
	input wire logic sec_tick,
	// contact
	input wire logic normal_state,
	output logic coil_ff,
	output logic held_ff
);
	import otov_pkg::*;

	otov_force_t mode_seen_ff;
	logic [DUR_W-1:0] dur_seen_ff;
	logic [DUR_W-1:0] secs_ff;
	logic changed;
	logic timed_out;

	assign changed = (force_mode != mode_seen_ff) || (duration != dur_seen_ff);
	assign timed_out = (duration != '0) && (secs_ff > duration);

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			mode_seen_ff <= OTOV_FRC_OFF;
			dur_seen_ff <= '0;
		end else begin
			mode_seen_ff <= force_mode;
			dur_seen_ff <= duration;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			secs_ff <= '0;
		end else if (changed) begin
			secs_ff <= '0;
		end else if (sec_tick && force_mode != OTOV_FRC_OFF && duration != '0 && !timed_out) begin
			secs_ff <= secs_ff + 1'b1;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			coil_ff <= 1'b0;
			held_ff <= 1'b0;
		end else if (force_mode != OTOV_FRC_OFF && !timed_out && !changed) begin
			coil_ff <= (force_mode == OTOV_FRC_ON);
			held_ff <= 1'b1;
		end else if (force_mode != OTOV_FRC_OFF && !timed_out) begin
			// fresh setting starts acting one cycle later, once the timer has cleared
			coil_ff <= normal_state;
			held_ff <= 1'b0;
		end else begin
			coil_ff <= normal_state;
			held_ff <= 1'b0;
		end
	end

endmodule
`default_nettype wire

/* File: hw/otov_analog_scale.sv */
// loop current of one analog channel: normal, forced or power factor
`default_nettype none
`include "otov_map.svh"
module otov_analog_scale #(
	parameter int VAL_W = 16
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// settings
	input wire otov_pkg::otov_ana_cfg_t cfg,
	input wire logic [6:0] force_pct,
	input wire logic signed [VAL_W-1:0] min_val,
	input wire logic signed [VAL_W-1:0] max_val,
	// measurements
	input wire logic signed [VAL_W-1:0] param_val,
	input wire logic signed [VAL_W-1:0] pf_val,
	// loop current in microamps
	output logic [15:0] loop_ua_ff
);
	import otov_pkg::*;

	localparam int NW = VAL_W + 1;

	logic [15:0] lo_ua;
	logic [15:0] hi_ua;
	logic [NW-1:0] num;
	logic [NW-1:0] den;
	logic signed [NW-1:0] pf_c;
	logic signed [NW-1:0] pf_k;
	logic [15+NW:0] prod;
	logic [15:0] nxt_loop_ua;

	always_comb begin
		lo_ua = 16'h0000;
		hi_ua = `OTOV_UA_1MA;
		unique case (cfg.loop)
			OTOV_LOOP_0_1: begin
				hi_ua = `OTOV_UA_1MA;
			end
			OTOV_LOOP_0_20: begin
				hi_ua = `OTOV_UA_20MA;
			end
			OTOV_LOOP_4_20: begin
				lo_ua = `OTOV_UA_4MA;
				hi_ua = `OTOV_UA_20MA;
			end
			default: begin
				hi_ua = `OTOV_UA_1MA;
			end
		endcase
	end

	always_comb begin
		pf_c = NW'(pf_val);
		if (pf_val < VAL_W'(`OTOV_PF_MIN)) begin
			pf_c = NW'(`OTOV_PF_MIN);
		end else if (pf_val > VAL_W'(`OTOV_PF_MAX)) begin
			pf_c = NW'(`OTOV_PF_MAX);
		end
		// step order walks 0.00 up to 1.00, then -0.99 up to -0.01
		pf_k = (pf_c < 0) ? NW'(pf_c + NW'(200)) : pf_c;
		num = '0;
		den = NW'(1);
		if (force_pct != 7'h00) begin
			num = NW'(force_pct);
			den = NW'(`OTOV_PCT_MAX);
		end else if (cfg.pf_sel && !cfg.pf_step) begin
			num = NW'(pf_c - NW'(`OTOV_PF_MIN));
			den = NW'(`OTOV_PF_SPAN);
		end else if (cfg.pf_sel) begin
			num = NW'(NW'(`OTOV_PF_SPAN) - pf_k);
			den = NW'(`OTOV_PF_SPAN);
		end else if (param_val <= min_val) begin
			num = '0;
		end else if (param_val >= max_val) begin
			num = NW'(1);
		end else begin
			num = NW'(NW'(param_val) - NW'(min_val));
			den = NW'(NW'(max_val) - NW'(min_val));
		end
		prod = (16+NW)'(hi_ua - lo_ua) * (16+NW)'(num);
		nxt_loop_ua = lo_ua + 16'(prod / (16+NW)'(den));
		if (!cfg.enable) begin
			nxt_loop_ua = 16'h0000;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			loop_ua_ff <= 16'h0000;
		end else begin
			loop_ua_ff <= nxt_loop_ua;
		end
	end

endmodule
`default_nettype wire

/* File: hw/otov_top.sv */
// output test and override: contact forcing, analog forcing and scaling, register port
//
// Chosen here: strobed register access and the register offsets.
`default_nettype none
`include "otov_map.svh"
module otov_top #(
	parameter int unsigned TICK_CYCLES = `OTOV_TICK_S * `OTOV_CLK_HZ,
	parameter int NRELAY = 4,
	parameter int NANA = 4,
	parameter int DUR_W = 9
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	// contact outputs: 0 trip, 1 auxiliary one, 2 auxiliary two, 3 alarm
	input wire logic [NRELAY-1:0] prot_coil_in,
	output logic [NRELAY-1:0] coil_out,
	output logic [NRELAY-1:0] status_led,
	output logic service_led,
	// analog channels
	input wire logic [NANA-1:0][15:0] ana_param_in,
	input wire logic [15:0] pf_in,
	output logic [NANA-1:0][15:0] ana_loop_ua
);
	import otov_pkg::*;

	// ----------------------------------------
	// decoding helpers
	// ----------------------------------------
	function automatic logic in_bank(input logic [7:0] addr, input logic [7:0] base);
		in_bank = (addr[7:2] == base[7:2]);
	endfunction

	function automatic otov_force_t to_mode(input logic [1:0] code);
		to_mode = (code == 2'h3) ? OTOV_FRC_OFF : otov_force_t'(code);
	endfunction

	// ----------------------------------------
	// setting registers
	// ----------------------------------------
	otov_force_t relay_force_ff [NRELAY];
	logic [DUR_W-1:0] relay_dur_ff [NRELAY];
	logic [6:0] ana_force_ff [NANA];
	otov_ana_cfg_t ana_cfg_ff [NANA];
	logic [15:0] ana_min_ff [NANA];
	logic [15:0] ana_max_ff [NANA];
	logic [NRELAY-1:0] held;
	logic test_mode;
	logic [31:0] tick_cnt_ff;
	logic sec_tick_ff;
	logic [15:0] nxt_rdata;
	logic [15:0] rdata_ff;
	logic service_led_ff;
	logic wr_force;
	logic wr_dur;
	logic wr_pct;
	logic wr_cfg;
	logic wr_min;
	logic wr_max;

	// ----------------------------------------
	// write decode
	// ----------------------------------------
	// banks are four words apart, so the low address bits pick the unit
	assign wr_force = reg_wr && (reg_addr == `OTOV_ADDR_RELAY_FORCE);
	assign wr_dur = reg_wr && in_bank(reg_addr, `OTOV_ADDR_RELAY_DUR);
	assign wr_pct = reg_wr && in_bank(reg_addr, `OTOV_ADDR_ANA_FORCE);
	assign wr_cfg = reg_wr && in_bank(reg_addr, `OTOV_ADDR_ANA_CFG);
	assign wr_min = reg_wr && in_bank(reg_addr, `OTOV_ADDR_ANA_MIN);
	assign wr_max = reg_wr && in_bank(reg_addr, `OTOV_ADDR_ANA_MAX);

	// ----------------------------------------
	// register writes
	// ----------------------------------------
	// reset clears every force
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < NRELAY; i++) begin
				relay_force_ff[i] <= OTOV_FRC_OFF;
			end
		end else if (wr_force) begin
			for (int i = 0; i < NRELAY; i++) begin
				relay_force_ff[i] <= to_mode(reg_wdata[2*i +: 2]);
			end
		end
	end

	// duration clamped to 300
	// longer settings are cut to the limit, not refused
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < NRELAY; i++) begin
				relay_dur_ff[i] <= '0;
			end
		end else if (wr_dur) begin
			if (reg_wdata > `OTOV_DUR_MAX) begin
				relay_dur_ff[reg_addr[1:0]] <= DUR_W'(`OTOV_DUR_MAX);
			end else begin
				relay_dur_ff[reg_addr[1:0]] <= DUR_W'(reg_wdata);
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < NANA; i++) begin
				ana_force_ff[i] <= 7'h00;
			end
		end else if (wr_pct) begin
			if (reg_wdata > 16'(`OTOV_PCT_MAX)) begin
				ana_force_ff[reg_addr[1:0]] <= `OTOV_PCT_MAX;
			end else begin
				ana_force_ff[reg_addr[1:0]] <= reg_wdata[6:0];
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < NANA; i++) begin
				ana_cfg_ff[i] <= otov_ana_cfg_t'(`OTOV_RST_ANA_CFG);
			end
		end else if (wr_cfg) begin
			ana_cfg_ff[reg_addr[1:0]] <= otov_ana_cfg_t'(reg_wdata[4:0]);
			// unused range code falls back to the narrowest loop
			if (reg_wdata[2:1] == 2'h3) begin
				ana_cfg_ff[reg_addr[1:0]].loop <= OTOV_LOOP_0_1;
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < NANA; i++) begin
				ana_min_ff[i] <= `OTOV_RST_ANA_MIN;
			end
		end else if (wr_min) begin
			ana_min_ff[reg_addr[1:0]] <= reg_wdata;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < NANA; i++) begin
				ana_max_ff[i] <= `OTOV_RST_ANA_MAX;
			end
		end else if (wr_max) begin
			ana_max_ff[reg_addr[1:0]] <= reg_wdata;
		end
	end

	// ----------------------------------------
	// seconds timebase
	// ----------------------------------------
	// free running, so a timed force lasts between N and N+1 seconds
	// one-cycle pulse, so each timer counts a given second once
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			tick_cnt_ff <= 32'h00000000;
			sec_tick_ff <= 1'b0;
		end else if (tick_cnt_ff >= TICK_CYCLES - 1) begin
			tick_cnt_ff <= 32'h00000000;
			sec_tick_ff <= 1'b1;
		end else begin
			tick_cnt_ff <= tick_cnt_ff + 32'h00000001;
			sec_tick_ff <= 1'b0;
		end
	end

	// ----------------------------------------
	// contact outputs
	// ----------------------------------------
	generate
		// each contact times its own force from the shared tick
		for (genvar r = 0; r < NRELAY; r++) begin : g_relay
			otov_relay_force #(
				.DUR_W(DUR_W)
			) u_relay (
				.sys_clk(sys_clk),
				.rst(rst),
				.force_mode(relay_force_ff[r]),
				.duration(relay_dur_ff[r]),
				.sec_tick(sec_tick_ff),
				.normal_state(prot_coil_in[r]),
				.coil_ff(coil_out[r]),
				.held_ff(held[r])
			);
		end
	endgenerate

	assign status_led = coil_out;

	always_comb begin
		test_mode = 1'b0;
		for (int i = 0; i < NRELAY; i++) begin
			test_mode = test_mode | (relay_force_ff[i] != OTOV_FRC_OFF);
		end
	end

	// registered so the lamp only changes on a clock edge
	// service lamp
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			service_led_ff <= 1'b0;
		end else begin
			service_led_ff <= test_mode;
		end
	end

	assign service_led = service_led_ff;

	// ----------------------------------------
	// analog outputs
	// ----------------------------------------
	generate
		for (genvar a = 0; a < NANA; a++) begin : g_ana
			otov_analog_scale #(
				.VAL_W(16)
			) u_scale (
				.sys_clk(sys_clk),
				.rst(rst),
				.cfg(ana_cfg_ff[a]),
				.force_pct(ana_force_ff[a]),
				.min_val(ana_min_ff[a]),
				.max_val(ana_max_ff[a]),
				.param_val(ana_param_in[a]),
				.pf_val(pf_in),
				.loop_ua_ff(ana_loop_ua[a])
			);
		end
	endgenerate

	// ----------------------------------------
	// register read back
	// ----------------------------------------
	// status is read live, so a poll sees a release at once
	always_comb begin
		nxt_rdata = 16'h0000;
		if (reg_addr == `OTOV_ADDR_RELAY_FORCE) begin
			for (int i = 0; i < NRELAY; i++) begin
				nxt_rdata[2*i +: 2] = relay_force_ff[i];
			end
		end else if (reg_addr == `OTOV_ADDR_STATUS) begin
			nxt_rdata[`OTOV_ST_COIL_LSB +: NRELAY] = coil_out;
			nxt_rdata[`OTOV_ST_HELD_LSB +: NRELAY] = held;
			nxt_rdata[`OTOV_ST_TEST_BIT] = test_mode;
		end else if (in_bank(reg_addr, `OTOV_ADDR_RELAY_DUR)) begin
			nxt_rdata = 16'(relay_dur_ff[reg_addr[1:0]]);
		end else if (in_bank(reg_addr, `OTOV_ADDR_ANA_FORCE)) begin
			nxt_rdata = 16'(ana_force_ff[reg_addr[1:0]]);
		end else if (in_bank(reg_addr, `OTOV_ADDR_ANA_CFG)) begin
			nxt_rdata = 16'(ana_cfg_ff[reg_addr[1:0]]);
		end else if (in_bank(reg_addr, `OTOV_ADDR_ANA_MIN)) begin
			nxt_rdata = ana_min_ff[reg_addr[1:0]];
		end else if (in_bank(reg_addr, `OTOV_ADDR_ANA_MAX)) begin
			nxt_rdata = ana_max_ff[reg_addr[1:0]];
		end
	end

	// data stand only in the cycle after the strobe, zero otherwise
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rdata_ff <= 16'h0000;
		end else if (reg_rd) begin
			rdata_ff <= nxt_rdata;
		end else begin
			rdata_ff <= 16'h0000;
		end
	end

	assign reg_rdata = rdata_ff;

endmodule
`default_nettype wire

/* File: testbench/otov_props.sv */
// port assertions of the output test block
`default_nettype none
module otov_props #(
	parameter int unsigned TICK_CYCLES = 20,
	parameter int NRELAY = 4,
	parameter int NANA = 4,
	parameter int DUR_W = 9
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	// contacts and loops
	input wire logic [NRELAY-1:0] prot_coil_in,
	input wire logic [NRELAY-1:0] coil_out,
	input wire logic [NRELAY-1:0] status_led,
	input wire logic service_led,
	input wire logic [NANA-1:0][15:0] ana_loop_ua
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	logic wr_frc;
	assign wr_frc = reg_wr && reg_addr == 8'h00;
	// code 3 is clamped to disabled, so it must not light the lamp
	function automatic logic any_on(input logic [15:0] w);
		any_on = 1'b0;
		for (int i = 0; i < 4; i++) begin
			if (w[2*i+:2] == 2'h1 || w[2*i+:2] == 2'h2) begin
				any_on = 1'b1;
			end
		end
	endfunction
	a_lamp_mirror: assert property (status_led == coil_out)
		else $error("status lamp differs from coil");
	a_service_on: assert property (wr_frc && any_on(reg_wdata) |-> ##[1:2] service_led)
		else $error("service lamp not lit by force");
	a_service_off: assert property (wr_frc && !any_on(reg_wdata) |-> ##[1:2] !service_led)
		else $error("service lamp stays after disable");
	a_trip_on: assert property (wr_frc && reg_wdata[1:0] == 2'h1 |-> ##[2:3] coil_out[0])
		else $error("trip not energized by force");
	a_trip_drop: assert property (wr_frc && reg_wdata[1:0] == 2'h2 |-> ##[2:3] !coil_out[0])
		else $error("trip not dropped by force");
	a_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
		else $error("read data outside its cycle");
	a_rd_unmapped: assert property (reg_rd && reg_addr == 8'h02 |=> reg_rdata == 16'h0000)
		else $error("unmapped read not zero");
	a_power_clear: assert property ($fell(rst) |-> !service_led && coil_out == '0 ##1
		!service_led && coil_out == $past(prot_coil_in))
		else $error("forcing survived power loss");
	a_follow_norm: assert property (!service_led [*3] |-> coil_out == $past(prot_coil_in))
		else $error("coil ignores normal demand");
	for (genvar i = 0; i < NANA; i++) begin : g_ch
		a_loop_max: assert property (ana_loop_ua[i] <= 16'h4E20)
			else $error("loop current beyond range");
	end
endmodule
bind otov_top otov_props #(
	.TICK_CYCLES(TICK_CYCLES), .NRELAY(NRELAY), .NANA(NANA), .DUR_W(DUR_W)
) u_props (
	.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
	.prot_coil_in, .coil_out, .status_led, .service_led, .ana_loop_ua
);
`default_nettype wire

/* File: testbench/otov_plant.sv */
// contactor coil and loop receiver model on the far side
`default_nettype none
module otov_plant #(
	parameter bit SLOW = 1'b1
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// driven side
	input wire logic [3:0] coil_out,
	input wire logic [15:0] loop_ua,
	// feedback
	output logic [3:0] contact,
	output logic loop_ok_ff
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] pick_ff;
	logic [3:0] hold_ff;
	// a slow armature closes one cycle later
	assign contact = SLOW ? hold_ff : pick_ff;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pick_ff <= 4'h0;
			hold_ff <= 4'h0;
			loop_ok_ff <= 1'b0;
		end else begin
			pick_ff <= coil_out;
			hold_ff <= pick_ff;
			// receiver reports the loop good only up to full scale
			loop_ok_ff <= loop_ua <= 16'h4E20;
		end
	end
endmodule
`default_nettype wire

/* File: testbench/otov_top_tb_top.sv */
// self-checking bench of the output test block
`default_nettype none
module otov_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TICK = 20;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic rd_pend = 1'b0;
	logic [15:0] reg_rdata;
	logic [3:0] prot_coil_in = 4'h0;
	logic [3:0] coil_out;
	logic [3:0] status_led;
	logic [3:0] contact;
	logic service_led;
	logic loop_ok;
	logic [3:0][15:0] ana_param_in = '0;
	logic [15:0] pf_in = 16'h0000;
	logic [3:0][15:0] ana_loop_ua;
	logic [15:0] exp_q[$];
	int bad_count = 0;
	int cmp_count = 0;
	int pf_tab[3] = '{-1, 0, -99};
	always #10 sys_clk = ~sys_clk;
	otov_top #(.TICK_CYCLES(TICK)) dut (
		.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.prot_coil_in, .coil_out, .status_led, .service_led,
		.ana_param_in, .pf_in, .ana_loop_ua
	);
	otov_plant #(.SLOW(1'b1)) u_plant (
		.sys_clk, .rst, .coil_out, .loop_ua(ana_loop_ua[0]), .contact, .loop_ok_ff(loop_ok)
	);
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#2;
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		exp_q.push_back(e);
		@(posedge sys_clk);
		reg_rd <= 1'b0;
	endtask
	function automatic logic [15:0] ua(input int lo, input int hi, input int num, input int den);
		ua = 16'(lo + (hi - lo) * num / den);
	endfunction
	// read data stands only in the cycle after the strobe
	always @(posedge sys_clk) begin
		if (rd_pend) begin
			chk(reg_rdata, exp_q.pop_front());
		end
		rd_pend <= reg_rd;
	end
	task automatic end_sim();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	initial begin
		#200000;
		bad_count++;
		$display("BAD %0t watchdog expired", $time);
		end_sim();
	end
	initial begin
		int pf;
		int k;
		void'($urandom(32'had03a9ad));
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		prot_coil_in <= 4'($urandom);
		cyc(3);
		chk({12'h0, coil_out}, {12'h0, prot_coil_in});
		// demand opposes each force, code 3 must read as disabled
		for (int m = 1; m < 4; m++) begin
			@(posedge sys_clk);
			prot_coil_in <= (m == 1) ? 4'h0 : 4'hF;
			wr(8'h00, {8'h00, {4{m[1:0]}}});
			cyc(5 * TICK);
			chk({12'h0, coil_out}, (m == 2) ? 16'h0000 : 16'h000F);
			chk({12'h0, contact}, {12'h0, coil_out});
			chk({12'h0, status_led}, (m == 2) ? 16'h0000 : 16'h000F);
			chk({15'h0, service_led}, {15'h0, m != 3});
			rd(8'h01, (m == 1) ? 16'h01FF : (m == 2) ? 16'h01F0 : 16'h000F);
		end
		// timed trip force runs out, test mode stays
		@(posedge sys_clk);
		prot_coil_in <= 4'h0;
		wr(8'h04, 16'h0002);
		wr(8'h00, 16'h0001);
		cyc(2 * TICK - 5);
		chk({12'h0, coil_out}, 16'h0001);
		cyc(TICK + 10);
		chk({12'h0, coil_out}, 16'h0000);
		chk({15'h0, service_led}, 16'h0001);
		rd(8'h01, 16'h0100);
		wr(8'h04, 16'hFFFF);
		rd(8'h04, 16'h012C);
		wr(8'h00, 16'h0000);
		cyc(3);
		chk({15'h0, service_led}, 16'h0000);
		// power loss in the middle of a force
		wr(8'h00, 16'h0055);
		cyc(5);
		@(posedge sys_clk);
		rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		prot_coil_in <= 4'($urandom);
		cyc(3);
		chk({12'h0, coil_out}, {12'h0, prot_coil_in});
		chk({15'h0, service_led}, 16'h0000);
		rd(8'h00, 16'h0000);
		rd(8'h0E, 16'h0000);
		rd(8'h17, 16'h0064);
		rd(8'h02, 16'h0000);
		chk(ana_loop_ua[2] | ana_loop_ua[3], 16'h0000);
		// one percent on every loop range
		wr(8'h08, 16'h0001);
		for (int r = 0; r < 3; r++) begin
			wr(8'h0C, 16'(1 + 2 * r));
			cyc(3);
			chk(ana_loop_ua[0], ua(r == 2 ? 4000 : 0, r == 0 ? 1000 : 20000, 1, 100));
		end
		wr(8'h08, 16'h00FF);
		cyc(3);
		chk(ana_loop_ua[0], 16'h4E20);
		chk({15'h0, loop_ok}, 16'h0001);
		wr(8'h08, 16'h0032);
		cyc(3);
		chk(ana_loop_ua[0], 16'h2EE0);
		wr(8'h0C, 16'h0004);
		cyc(3);
		chk(ana_loop_ua[0], 16'h0000);
		wr(8'h0C, 16'h0005);
		wr(8'h08, 16'h0000);
		repeat (4) begin
			k = int'($urandom_range(150));
			@(posedge sys_clk);
			ana_param_in <= {16'($urandom), 16'($urandom), 16'($urandom), 16'(k)};
			cyc(3);
			chk(ana_loop_ua[0], ua(4000, 20000, k > 100 ? 100 : k, 100));
		end
		// power factor on channel 1, flat then step
		for (int s = 0; s < 2; s++) begin
			wr(8'h0D, s ? 16'h001D : 16'h000D);
			for (int j = 0; j < 5; j++) begin
				pf = (j < 3) ? pf_tab[j] : int'($urandom_range(199)) - 99;
				@(posedge sys_clk);
				pf_in <= 16'(pf);
				cyc(3);
				k = (pf < 0) ? pf + 200 : pf;
				k = s ? 199 - k : pf + 99;
				chk(ana_loop_ua[1], ua(4000, 20000, k, 199));
			end
		end
		cyc(3);
		end_sim();
	end
endmodule
`default_nettype wire
